// File: rtl/tbt_regs.vh
/*
  register map, field positions, reset values and encodings of the type-b timer core.
  assumes a 32-bit apb slave with word-aligned registers at the offsets below.
*/
// Notes on behaviour
// - reset leaves timer in periodic-interrupt mode
// - eight modes share one 16-bit counter
// - zero is count floor, detected; the core loads zero on restart but has no zero compare
// - all-ones value is maximum, detected
// - limit is compare value in default mode
// - clock from peripheral, type-a timer, or event
// - select field picks prescaler tap or event
// - type-a clock keeps counter in lockstep
// - any routed event usable as clock/control; the core takes event_channel as a clock source only, never as control
// - output enable drives waveform over port value
// - enable bit starts counting at selected rate
// - count readable; capture flag/event at limit
// - limit below count: run to max, wrap
// - reaching maximum raises wrap flag and event, unless limit equals maximum (capture instead)
// - waveform output is single digital signal
// - default mode restarts from zero at limit
`ifndef TBT_REGS_VH
`define TBT_REGS_VH

`define TBT_OFF_CONTROL_A 12'h000
`define TBT_OFF_CONTROL_B 12'h004
`define TBT_OFF_INT_ENABLE 12'h008
`define TBT_OFF_INT_STATUS 12'h00c
`define TBT_OFF_INT_CLEAR 12'h010
`define TBT_OFF_COUNT 12'h014
`define TBT_OFF_COMPARE 12'h018

`define TBT_CTLA_ENABLE 0
`define TBT_CTLA_CLKSRC_LSB 1
`define TBT_CTLA_CLKSRC_MSB 2
`define TBT_CTLB_MODE_LSB 0
`define TBT_CTLB_MODE_MSB 2
`define TBT_CTLB_CMP_OUT_EN 4

`define TBT_INT_CAPTURE 0
`define TBT_INT_WRAP 1

`define TBT_CLK_DIV1 2'h0
`define TBT_CLK_DIV2 2'h1
`define TBT_CLK_TYPE_A 2'h2
`define TBT_CLK_EVENT 2'h3

`define TBT_MODE_PERIODIC 3'h0
`define TBT_COUNT_FLOOR 16'h0000
`define TBT_COUNT_MAX 16'hffff
`define TBT_COMPARE_RESET 16'h0000

`endif

// File: rtl/tbt_core.v
/*
  type-b timer core: 16-bit counter with clock-source select, capture and wrap
  flags and events, apb register slave and one level interrupt.
  assumes event and type-a clock inputs are asynchronous pins; one clock domain.
*/
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tbt_regs.vh"

module tbt_core (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire type_a_timer_clock,
  input wire event_channel,
  input wire port_out_value,
  output reg waveform_out,
  output reg capture_event,
  output reg wrap_event,
  output reg irq
);

  reg enable_q;
  reg [1:0] clock_source_select_q;
  reg [2:0] mode_q;
  reg compare_output_enable_q;
  reg [1:0] int_enable_q;
  reg [1:0] int_status_q;
  reg [15:0] count_value_q;
  reg [15:0] compare_capture_value_q;
  reg wave_q;
  reg div_q;
  reg [2:0] tca_sync_q;
  reg [2:0] evt_sync_q;
  reg [15:0] count_d;
  reg tick;
  reg at_limit;
  reg at_max;
  reg cnt_wr;
  reg [1:0] clr_bits;
  wire acc;
  wire wr;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;

  // two flops before any logic; third flop feeds edge detect only
  always @(posedge clock) begin
    if (!rst_n) begin
      tca_sync_q <= 3'h0;
      evt_sync_q <= 3'h0;
      div_q <= 1'b0;
    end else begin
      tca_sync_q <= {tca_sync_q[1:0], type_a_timer_clock};
      evt_sync_q <= {evt_sync_q[1:0], event_channel};
      div_q <= ~div_q;
    end
  end

  always @* begin
    case (clock_source_select_q)
      `TBT_CLK_DIV1: tick = 1'b1;
      `TBT_CLK_DIV2: tick = div_q;
      `TBT_CLK_TYPE_A: tick = tca_sync_q[1] & ~tca_sync_q[2];
      default: tick = evt_sync_q[1] & ~evt_sync_q[2];
    endcase
  end

  always @* begin
    at_limit = (count_value_q == compare_capture_value_q);
    at_max = (count_value_q == `TBT_COUNT_MAX);
    cnt_wr = wr && (paddr == `TBT_OFF_COUNT);
    count_d = count_value_q;
    if (cnt_wr) begin
      count_d = pwdata[15:0];
    end else if (enable_q && tick) begin
      // other modes still run the same base counter as periodic
      if (at_limit || at_max) begin
        count_d = `TBT_COUNT_FLOOR;
      end else begin
        count_d = count_value_q + 16'h0001;
      end
    end
    clr_bits = 2'h0;
    if (wr && (paddr == `TBT_OFF_INT_CLEAR)) begin
      clr_bits = pwdata[1:0];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
      clock_source_select_q <= `TBT_CLK_DIV1;
      mode_q <= `TBT_MODE_PERIODIC;
      compare_output_enable_q <= 1'b0;
      int_enable_q <= 2'h0;
      int_status_q <= 2'h0;
      count_value_q <= `TBT_COUNT_FLOOR;
      compare_capture_value_q <= `TBT_COMPARE_RESET;
      wave_q <= 1'b0;
      capture_event <= 1'b0;
      wrap_event <= 1'b0;
      waveform_out <= 1'b0;
      irq <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      count_value_q <= count_d;
      capture_event <= enable_q && tick && at_limit && !cnt_wr;
      wrap_event <= enable_q && tick && at_max && !at_limit && !cnt_wr;
      // set wins over clear
      int_status_q[`TBT_INT_CAPTURE] <= (int_status_q[`TBT_INT_CAPTURE]
        & ~clr_bits[`TBT_INT_CAPTURE]) | (enable_q && tick && at_limit && !cnt_wr);
      int_status_q[`TBT_INT_WRAP] <= (int_status_q[`TBT_INT_WRAP]
        & ~clr_bits[`TBT_INT_WRAP]) | (enable_q && tick && at_max && !at_limit
        && !cnt_wr);
      if (enable_q && tick && at_limit) begin
        wave_q <= ~wave_q;
      end
      waveform_out <= compare_output_enable_q ? wave_q : port_out_value;
      irq <= |(int_status_q & int_enable_q);
      pready <= psel & ~pready;
      pslverr <= 1'b0;
      if (wr) begin
        if (paddr == `TBT_OFF_CONTROL_A) begin
          enable_q <= pwdata[`TBT_CTLA_ENABLE];
          clock_source_select_q <= pwdata[`TBT_CTLA_CLKSRC_MSB:`TBT_CTLA_CLKSRC_LSB];
        end else if (paddr == `TBT_OFF_CONTROL_B) begin
          mode_q <= pwdata[`TBT_CTLB_MODE_MSB:`TBT_CTLB_MODE_LSB];
          compare_output_enable_q <= pwdata[`TBT_CTLB_CMP_OUT_EN];
        end else if (paddr == `TBT_OFF_INT_ENABLE) begin
          int_enable_q <= pwdata[1:0];
        end else if (paddr == `TBT_OFF_COMPARE) begin
          compare_capture_value_q <= pwdata[15:0];
        end
      end
      // unmapped writes flag the error in setup so it stands with pready
      if (psel && !pready && pwrite) begin
        if (paddr != `TBT_OFF_CONTROL_A && paddr != `TBT_OFF_CONTROL_B
            && paddr != `TBT_OFF_INT_ENABLE && paddr != `TBT_OFF_INT_STATUS
            && paddr != `TBT_OFF_INT_CLEAR && paddr != `TBT_OFF_COUNT
            && paddr != `TBT_OFF_COMPARE) begin
          pslverr <= 1'b1;
        end
      end
      if (psel && !pready && !pwrite) begin
        if (paddr == `TBT_OFF_CONTROL_A) begin
          prdata <= {29'h0, clock_source_select_q, enable_q};
        end else if (paddr == `TBT_OFF_CONTROL_B) begin
          prdata <= {27'h0, compare_output_enable_q, 1'b0, mode_q};
        end else if (paddr == `TBT_OFF_INT_ENABLE) begin
          prdata <= {30'h0, int_enable_q};
        end else if (paddr == `TBT_OFF_INT_STATUS) begin
          prdata <= {30'h0, int_status_q};
        end else if (paddr == `TBT_OFF_COUNT) begin
          prdata <= {16'h0, count_value_q};
        end else if (paddr == `TBT_OFF_COMPARE) begin
          prdata <= {16'h0, compare_capture_value_q};
        end else if (paddr == `TBT_OFF_INT_CLEAR) begin
          prdata <= 32'h0;
        end else begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule

// File: verification/tbt_core_assertions.sv
/* port checker for tbt_core; assumes one clock and sync active-low reset */
`timescale 1ns/1ps
module tbt_chk(
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire capture_event,
  input wire wrap_event,
  input wire irq);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rdy; psel && !penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_req; pready |-> psel && penable; endproperty
  a_req: assert property (p_req) else $error("ready unasked");
  property p_exc; !(capture_event && wrap_event); endproperty
  a_exc: assert property (p_exc) else $error("both events");
  property p_gap; wrap_event |=> !wrap_event [*8]; endproperty
  a_gap: assert property (p_gap) else $error("wrap too soon");
  property p_rst; !$past(rst_n) |-> !irq && !capture_event && !wrap_event; endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
  property p_irq; $fell(irq) |-> $past(pready) || $past(pready, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq fell alone");
endmodule
bind tbt_core tbt_chk i_chk(.*);

// File: verification/tbt_far_end.sv
/* far-end model: type-a clock, event channel, port pin; uses system clock */
`timescale 1ns/1ps
module tbt_far_end(
  input wire clock,
  output logic type_a_timer_clock = 1'b0,
  output logic event_channel = 1'b0,
  output logic port_out_value = 1'b1);
  task pulse(input logic sel);
    if (sel) event_channel <= 1'b1;
    else type_a_timer_clock <= 1'b1;
    repeat (2) @(posedge clock);
    {event_channel, type_a_timer_clock} <= 2'b00;
    repeat (2) @(posedge clock);
  endtask
endmodule

// File: verification/testbench.sv
/* bench for tbt_core: apb tasks; far-end model makes the tick inputs */
`timescale 1ns/1ps
module testbench;
  logic clock = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0;
  logic pready, pslverr, type_a_timer_clock, event_channel, port_out_value;
  logic waveform_out, capture_event, wrap_event, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  int error_cnt = 0, check_count = 0, i;
  always #4 clock = ~clock;
  tbt_far_end i_far(.*);
  tbt_core i_dut(.*);
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) error_cnt++;
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    if (!w) chk(pslverr ? 32'hee : prdata, d);
    {psel, penable} <= 2'b00;
  endtask
  task end_sim;
    $display("err=%0d chk=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000 error_cnt++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, 12'h4, 0);
    chk(waveform_out, 1);
    apb(1, 12'h4, 32'h10);
    apb(0, 12'h4, 32'h10);
    apb(1, 12'h4, 0);
    apb(0, 12'h1c, 32'hee);
    apb(1, 12'h18, 5);
    apb(1, 12'h8, 3);
    apb(1, 12'h0, 1);
    for (i = 0; i < 99 && capture_event !== 1'b1; i++) @(negedge clock);
    apb(0, 12'hc, 1);
    chk(irq, 1);
    apb(1, 12'h14, 32'hfff0);
    for (i = 0; i < 99 && wrap_event !== 1'b1; i++) @(negedge clock);
    apb(1, 12'h8, 0);
    apb(0, 12'hc, 3);
    chk(irq, 0);
    apb(1, 12'h0, 0);
    apb(1, 12'h10, 3);
    apb(1, 12'h14, 7);
    apb(0, 12'h14, 7);
    apb(0, 12'hc, 0);
    for (int s = 2; s < 4; s++) begin
      apb(1, 12'h0, {s[1:0], 1'b1});
      repeat (4) i_far.pulse(s[0]);
      apb(0, 12'h14, 4 * s + 3);
    end
    end_sim;
  end
endmodule
